/* hdl/lmbs_dev.sv */
// Purpose: LED matrix device end: registers, scan, PWM, breath and fault capture.
// Assumes: Link wires and fault inputs come from other domains and are synchronised.
// Notes: Dot d sits on row d/4 and column d%4.
//
// Design decision made here: strobed register access.
`include "lmbs_map.svh"
`timescale 1ns/100ps
`default_nettype none
module lmbs_dev #(
  parameter int BASE_TICKS = `LMBS_BASE_TICKS
) (
  input wire logic core_clk_in, // Core clock.
  input wire logic rst_n_in, // Asynchronous reset, active low.
  lmbs_if.dev lnk, // Link to the host.
  input wire logic [11:0] dot_open_in, // Open sense per dot.
  input wire logic [11:0] dot_short_in, // Short sense per dot.
  output logic [2:0] row_switch_out, // Row switch on, active high.
  output logic [3:0] column_source_out, // Column source on.
  output logic [7:0] global_current_value_out, // Column current scale.
  output logic [2:0] row_pullup_code_out, // Row pull-up selection.
  output logic [2:0] row_pullup_en_out, // Row pull-up connected.
  output logic [2:0] column_pulldown_code_out, // Column pull-down selection.
  output logic [3:0] column_pulldown_en_out // Column pull-down connected.
);
  localparam logic [10:0] SLOT_CYC = 11'(`LMBS_SLOT_NS / `LMBS_CLK_NS);
  localparam logic [10:0] GAP_CYC = 11'(`LMBS_GAP_NS / `LMBS_CLK_NS);
  localparam logic [11:0] UNIT_CYC = 12'(BASE_TICKS / 1024);

  function automatic logic dot_hit(input logic [7:0] a, input logic [7:0] base);
    dot_hit = (a[7:4] == base[7:4]) && (a[3:0] < 4'hc);
  endfunction

  // ****************************************************************
  // Link synchroniser
  // ****************************************************************
  logic [18:0] ls1_r, ls2_r;
  logic [23:0] fs1_r, fs2_r;
  logic lclk3_r;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ls1_r <= '0;
      ls2_r <= '0;
      fs1_r <= '0;
      fs2_r <= '0;
      lclk3_r <= 1'b0;
    end else begin
      ls1_r <= {lnk.lnk_clk, lnk.lnk_wr, lnk.lnk_rd, lnk.lnk_addr, lnk.lnk_wdata};
      ls2_r <= ls1_r;
      fs1_r <= {dot_short_in, dot_open_in};
      fs2_r <= fs1_r;
      lclk3_r <= ls2_r[18];
    end
  end
  logic lnk_edge, do_wr, do_rd;
  logic [7:0] la, ld;
  assign lnk_edge = ls2_r[18] && !lclk3_r;
  assign do_wr = lnk_edge && ls2_r[17];
  assign do_rd = lnk_edge && ls2_r[16];
  assign la = ls2_r[15:8];
  assign ld = ls2_r[7:0];

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [2:0] cfg_r, cfg_nxt;
  logic [7:0] gcc_r, gcc_nxt, rdata_r, rdata_nxt;
  logic [7:0] shadow_r [12], shadow_nxt [12], act_r [12], act_nxt [12];
  logic [7:0] pwm_r [12], pwm_nxt [12];
  logic [1:0] mode_r [12], mode_nxt [12];
  logic [2:0] pu_r, pu_nxt, pd_r, pd_nxt;
  logic [11:0] onoff_r, onoff_nxt, open_r, open_nxt, short_r, short_nxt;
  logic det_fire, restart;
  always_comb begin
    cfg_nxt = cfg_r;
    gcc_nxt = gcc_r;
    shadow_nxt = shadow_r;
    act_nxt = act_r;
    pwm_nxt = pwm_r;
    mode_nxt = mode_r;
    pu_nxt = pu_r;
    pd_nxt = pd_r;
    onoff_nxt = onoff_r;
    open_nxt = open_r;
    short_nxt = short_r;
    rdata_nxt = rdata_r;
    if (det_fire) begin
      open_nxt = (open_r & ~onoff_r) | (fs2_r[11:0] & onoff_r);
      short_nxt = (short_r & ~onoff_r) | (fs2_r[23:12] & onoff_r);
    end
    if (do_wr) begin
      if (la >= `LMBS_TIME_FIRST && la <= `LMBS_TIME_LAST)
        shadow_nxt[4'(la - `LMBS_TIME_FIRST)] = ld;
      else if (dot_hit(la, `LMBS_PWM_BASE))
        pwm_nxt[la[3:0]] = ld;
      else if (dot_hit(la, `LMBS_MODE_BASE))
        mode_nxt[la[3:0]] = ld[1:0];
      else begin
        case (la)
          `LMBS_CFG: cfg_nxt = ld[2:0];
          `LMBS_GCC: gcc_nxt = ld;
          `LMBS_COMMIT: if (ld == `LMBS_COMMIT_KEY) act_nxt = shadow_r;
          `LMBS_PULLUP: pu_nxt = ld[2:0];
          `LMBS_PULLDOWN: pd_nxt = ld[2:0];
          `LMBS_ONOFF_LO: onoff_nxt[7:0] = ld;
          `LMBS_ONOFF_HI: onoff_nxt[11:8] = ld[3:0];
          default: ;
        endcase
      end
    end
    if (do_rd) begin
      if (dot_hit(la, `LMBS_PWM_BASE))
        rdata_nxt = pwm_r[la[3:0]];
      else if (dot_hit(la, `LMBS_MODE_BASE))
        rdata_nxt = {6'h00, mode_r[la[3:0]]};
      else begin
        case (la)
          `LMBS_CFG: rdata_nxt = {5'h00, cfg_r};
          `LMBS_GCC: rdata_nxt = gcc_r;
          `LMBS_OPEN_LO: rdata_nxt = open_r[7:0];
          `LMBS_OPEN_HI: rdata_nxt = {4'h0, open_r[11:8]};
          `LMBS_SHORT_LO: rdata_nxt = short_r[7:0];
          `LMBS_SHORT_HI: rdata_nxt = {4'h0, short_r[11:8]};
          `LMBS_ONOFF_LO: rdata_nxt = onoff_r[7:0];
          `LMBS_ONOFF_HI: rdata_nxt = {4'h0, onoff_r[11:8]};
          default: rdata_nxt = 8'h00;
        endcase
      end
      if (la == `LMBS_RESET) begin
        cfg_nxt = '0;
        gcc_nxt = `LMBS_REG_RESET;
        pu_nxt = '0;
        pd_nxt = '0;
        onoff_nxt = '0;
        open_nxt = '0;
        short_nxt = '0;
        for (int i = 0; i < 12; i++) begin
          shadow_nxt[i] = `LMBS_REG_RESET;
          act_nxt[i] = `LMBS_REG_RESET;
          pwm_nxt[i] = `LMBS_REG_RESET;
          mode_nxt[i] = 2'h0;
        end
      end
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_r <= '0;
      gcc_r <= `LMBS_REG_RESET;
      pu_r <= '0;
      pd_r <= '0;
      onoff_r <= '0;
      open_r <= '0;
      short_r <= '0;
      rdata_r <= 8'h00;
      for (int i = 0; i < 12; i++) begin
        shadow_r[i] <= `LMBS_REG_RESET;
        act_r[i] <= `LMBS_REG_RESET;
        pwm_r[i] <= `LMBS_REG_RESET;
        mode_r[i] <= 2'h0;
      end
    end else begin
      cfg_r <= cfg_nxt;
      gcc_r <= gcc_nxt;
      shadow_r <= shadow_nxt;
      act_r <= act_nxt;
      pwm_r <= pwm_nxt;
      mode_r <= mode_nxt;
      pu_r <= pu_nxt;
      pd_r <= pd_nxt;
      onoff_r <= onoff_nxt;
      open_r <= open_nxt;
      short_r <= short_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign lnk.lnk_rdata = rdata_r;

  // ****************************************************************
  // Row scan, breath tick and detection control
  // ****************************************************************
  logic [1:0] row_r, row_nxt, dfr_r, dfr_nxt;
  logic [10:0] scnt_r, scnt_nxt;
  logic gap_r, gap_nxt, trig_r, trig_nxt, busy_r, busy_nxt, ben_r, ben_nxt;
  logic cmt_r, cmt_nxt;
  logic [11:0] ucnt_r, ucnt_nxt;
  logic tick;
  always_comb begin
    row_nxt = row_r;
    gap_nxt = gap_r;
    scnt_nxt = scnt_r + 11'h001;
    dfr_nxt = dfr_r;
    busy_nxt = busy_r;
    trig_nxt = cfg_r[`LMBS_CFG_DET];
    ben_nxt = cfg_r[`LMBS_CFG_BEN];
    cmt_nxt = do_wr && la == `LMBS_COMMIT && ld == `LMBS_COMMIT_KEY;
    ucnt_nxt = (ucnt_r + 12'h001 >= UNIT_CYC) ? 12'h000 : ucnt_r + 12'h001;
    det_fire = 1'b0;
    if (!gap_r && scnt_nxt == SLOT_CYC) begin
      gap_nxt = 1'b1;
      scnt_nxt = 11'h000;
    end else if (gap_r && scnt_nxt == GAP_CYC) begin
      gap_nxt = 1'b0;
      scnt_nxt = 11'h000;
      row_nxt = (row_r == 2'h2) ? 2'h0 : row_r + 2'h1;
      if (busy_r && row_r == 2'h2) begin
        dfr_nxt = dfr_r + 2'h1;
        if (dfr_nxt == `LMBS_DET_FRAMES) begin
          busy_nxt = 1'b0;
          det_fire = 1'b1;
        end
      end
    end
    if (cfg_r[`LMBS_CFG_DET] && !trig_r) begin
      busy_nxt = 1'b1;
      dfr_nxt = 2'h0;
    end
  end
  assign tick = (ucnt_r == 12'h000);
  // Restart one cycle after a commit, so that the new start phase is already active.
  assign restart = !ben_r || cmt_r;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      row_r <= 2'h0;
      gap_r <= 1'b0;
      scnt_r <= 11'h000;
      dfr_r <= 2'h0;
      busy_r <= 1'b0;
      trig_r <= 1'b0;
      ben_r <= 1'b0;
      cmt_r <= 1'b0;
      ucnt_r <= 12'h000;
    end else begin
      row_r <= row_nxt;
      gap_r <= gap_nxt;
      scnt_r <= scnt_nxt;
      dfr_r <= dfr_nxt;
      busy_r <= busy_nxt;
      trig_r <= trig_nxt;
      ben_r <= ben_nxt;
      cmt_r <= cmt_nxt;
      ucnt_r <= ucnt_nxt;
    end
  end

  // ****************************************************************
  // Breath profiles
  // ****************************************************************
  logic [9:0] lvl [3];
  for (genvar p = 0; p < 3; p++) begin : g_breath
    lmbs_pkg::lmbs_phase_e ph_r, ph_nxt;
    logic [19:0] cnt_r, cnt_nxt, len;
    logic [11:0] loop_r, loop_nxt, total;
    logic fin_r, fin_nxt;
    logic [2:0] rc, fc;
    logic [3:0] hc, oc;
    assign rc = act_r[p*4][7:5];
    assign hc = act_r[p*4][4:1];
    assign fc = act_r[p*4+1][7:5];
    assign oc = act_r[p*4+1][4:1];
    assign total = {act_r[p*4+2][3:0], act_r[p*4+3]};
    always_comb begin
      ph_nxt = ph_r;
      cnt_nxt = cnt_r;
      loop_nxt = loop_r;
      fin_nxt = fin_r;
      case (ph_r)
        lmbs_pkg::PH_RISE: len = 20'h00400 << rc;
        lmbs_pkg::PH_FALL: len = 20'h00400 << fc;
        lmbs_pkg::PH_HOLD: len = (hc == 4'h0) ? 20'h00000 : 20'h00400 << (hc - 4'h1);
        lmbs_pkg::PH_OFF: len = (oc == 4'h0) ? 20'h00000 : 20'h00400 << (oc - 4'h1);
        default: len = 20'h00000;
      endcase
      if (restart) begin
        cnt_nxt = 20'h00000;
        loop_nxt = 12'h000;
        fin_nxt = 1'b0;
        case (act_r[p*4+2][5:4])
          2'h0: ph_nxt = lmbs_pkg::PH_RISE;
          2'h1: ph_nxt = lmbs_pkg::PH_HOLD;
          2'h2: ph_nxt = lmbs_pkg::PH_FALL;
          default: ph_nxt = lmbs_pkg::PH_OFF;
        endcase
      end else if (tick && ph_r != lmbs_pkg::PH_DONE) begin
        cnt_nxt = cnt_r + 20'h00001;
        if (cnt_nxt >= len) begin
          cnt_nxt = 20'h00000;
          case (ph_r)
            lmbs_pkg::PH_RISE: ph_nxt = fin_r ? lmbs_pkg::PH_DONE : lmbs_pkg::PH_HOLD;
            lmbs_pkg::PH_HOLD: ph_nxt = lmbs_pkg::PH_FALL;
            lmbs_pkg::PH_FALL: begin
              loop_nxt = loop_r + 12'h001;
              ph_nxt = lmbs_pkg::PH_OFF;
              if (total != 12'h000 && loop_nxt == total) begin
                if (act_r[p*4+2][7:6] == 2'h0) ph_nxt = lmbs_pkg::PH_DONE;
                else fin_nxt = 1'b1;
              end
            end
            default: ph_nxt = lmbs_pkg::PH_RISE;
          endcase
        end
      end
    end
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        ph_r <= lmbs_pkg::PH_RISE;
        cnt_r <= 20'h00000;
        loop_r <= 12'h000;
        fin_r <= 1'b0;
      end else begin
        ph_r <= ph_nxt;
        cnt_r <= cnt_nxt;
        loop_r <= loop_nxt;
        fin_r <= fin_nxt;
      end
    end
    always_comb begin
      case (ph_r)
        lmbs_pkg::PH_RISE: lvl[p] = 10'(cnt_r >> rc);
        lmbs_pkg::PH_HOLD: lvl[p] = 10'h3ff;
        lmbs_pkg::PH_FALL: lvl[p] = 10'h3ff - 10'(cnt_r >> fc);
        lmbs_pkg::PH_DONE: lvl[p] = fin_r ? 10'h3ff : 10'h000;
        default: lvl[p] = 10'h000;
      endcase
    end
  end

  // ****************************************************************
  // Matrix drive
  // ****************************************************************
  logic [2:0] rsw_r, rsw_nxt, rpu_r, rpu_nxt;
  logic [3:0] col_r, col_nxt, cpd_r, cpd_nxt;
  logic run;
  assign run = cfg_r[`LMBS_CFG_SSD] && !gap_r;
  for (genvar c = 0; c < 4; c++) begin : g_col
    logic [3:0] d;
    logic [9:0] lv;
    assign d = 4'(row_r * 4 + c);
    always_comb begin
      if (cfg_r[`LMBS_CFG_BEN] && mode_r[d] != 2'h0)
        lv = lvl[mode_r[d] - 2'h1];
      else
        lv = {pwm_r[d], pwm_r[d][7:6]};
      col_nxt[c] = run && onoff_r[d] && ({1'b0, lv} > scnt_r);
      cpd_nxt[c] = (pd_r != 3'h0) && !col_nxt[c];
    end
  end
  always_comb begin
    for (int r = 0; r < 3; r++) begin
      rsw_nxt[r] = run && (row_r == 2'(r));
      rpu_nxt[r] = (pu_r != 3'h0) && !rsw_nxt[r];
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsw_r <= 3'h0;
      rpu_r <= 3'h0;
      col_r <= 4'h0;
      cpd_r <= 4'h0;
    end else begin
      rsw_r <= rsw_nxt;
      rpu_r <= rpu_nxt;
      col_r <= col_nxt;
      cpd_r <= cpd_nxt;
    end
  end
  assign row_switch_out = rsw_r;
  assign column_source_out = col_r;
  assign global_current_value_out = gcc_r;
  assign row_pullup_code_out = pu_r;
  assign row_pullup_en_out = rpu_r;
  assign column_pulldown_code_out = pd_r;
  assign column_pulldown_en_out = cpd_r;
endmodule // lmbs_dev
`default_nettype wire

/* hdl/lmbs_host.sv */
// Purpose: Host end: turns software register orders into link transfers.
// Assumes: Software polls status before issuing a new order.
// Notes: Link clock is the core clock divided by eight.
`include "lmbs_map.svh"
`timescale 1ns/100ps
`default_nettype none
module lmbs_host (
  input wire logic core_clk_in, // Core clock.
  input wire logic rst_n_in, // Asynchronous reset, active low.
  lmbs_if.host lnk, // Link to the device.
  input wire logic [2:0] sw_addr_in, // Software register address.
  input wire logic [7:0] sw_wdata_in, // Software write data.
  input wire logic sw_wr_in, // Software write strobe.
  input wire logic sw_rd_in, // Software read strobe.
  output logic [7:0] sw_rdata_out // Read data, one cycle after strobe.
);
  lmbs_pkg::lmbs_hstate_e st_r, st_nxt;
  logic [7:0] addr_r, addr_nxt, wd_r, wd_nxt, res_r, res_nxt, rdo_r, rdo_nxt, rs1_r, rs2_r;
  logic [2:0] div_r, div_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, isrd_r, isrd_nxt;
  logic lclk_r, lclk_nxt, lwr_r, lwr_nxt, lrd_r, lrd_nxt;
  // ****************************************************************
  // Order and transfer sequencing
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    res_nxt = res_r;
    div_nxt = div_r + 3'h1;
    busy_nxt = busy_r;
    done_nxt = done_r;
    isrd_nxt = isrd_r;
    lclk_nxt = lclk_r;
    lwr_nxt = lwr_r;
    lrd_nxt = lrd_r;
    rdo_nxt = 8'h00;
    if (sw_wr_in) begin
      case (sw_addr_in)
        `LMBS_H_ADDR: if (!busy_r) addr_nxt = sw_wdata_in;
        `LMBS_H_WDATA: if (!busy_r) wd_nxt = sw_wdata_in;
        `LMBS_H_CTRL: if (!busy_r && sw_wdata_in[1:0] != 2'h0) begin
          busy_nxt = 1'b1;
          done_nxt = 1'b0;
          isrd_nxt = sw_wdata_in[1];
          st_nxt = lmbs_pkg::HS_SETUP;
          div_nxt = 3'h0;
        end
        default: ;
      endcase
    end
    if (sw_rd_in) begin
      case (sw_addr_in)
        `LMBS_H_ADDR: rdo_nxt = addr_r;
        `LMBS_H_WDATA: rdo_nxt = wd_r;
        `LMBS_H_STATUS: rdo_nxt = {6'h00, done_r, busy_r};
        `LMBS_H_RDATA: rdo_nxt = res_r;
        default: rdo_nxt = 8'h00;
      endcase
    end
    case (st_r)
      lmbs_pkg::HS_SETUP: begin
        lwr_nxt = !isrd_r;
        lrd_nxt = isrd_r;
        if (div_r == `LMBS_LNK_HALF - 3'h1) begin
          lclk_nxt = 1'b1;
          div_nxt = 3'h0;
          st_nxt = lmbs_pkg::HS_HIGH;
        end
      end
      lmbs_pkg::HS_HIGH: if (div_r == `LMBS_LNK_HALF - 3'h1) begin
        lclk_nxt = 1'b0;
        lwr_nxt = 1'b0;
        lrd_nxt = 1'b0;
        div_nxt = 3'h0;
        st_nxt = lmbs_pkg::HS_TAIL;
      end
      lmbs_pkg::HS_TAIL: if (div_r == `LMBS_LNK_HALF - 3'h1) begin
        if (isrd_r) res_nxt = rs2_r;
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        st_nxt = lmbs_pkg::HS_IDLE;
      end
      default: ;
    endcase
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= lmbs_pkg::HS_IDLE;
      addr_r <= 8'h00;
      wd_r <= 8'h00;
      res_r <= 8'h00;
      rdo_r <= 8'h00;
      div_r <= 3'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      isrd_r <= 1'b0;
      lclk_r <= 1'b0;
      lwr_r <= 1'b0;
      lrd_r <= 1'b0;
      rs1_r <= 8'h00;
      rs2_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      res_r <= res_nxt;
      rdo_r <= rdo_nxt;
      div_r <= div_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      isrd_r <= isrd_nxt;
      lclk_r <= lclk_nxt;
      lwr_r <= lwr_nxt;
      lrd_r <= lrd_nxt;
      rs1_r <= lnk.lnk_rdata;
      rs2_r <= rs1_r;
    end
  end
  assign lnk.lnk_clk = lclk_r;
  assign lnk.lnk_wr = lwr_r;
  assign lnk.lnk_rd = lrd_r;
  assign lnk.lnk_addr = addr_r;
  assign lnk.lnk_wdata = wd_r;
  assign sw_rdata_out = rdo_r;
endmodule // lmbs_host
`default_nettype wire

/* hdl/lmbs_if.sv */
// Purpose: Link between host and LED matrix device.
// Assumes: Host makes the link clock; device samples every wire except lnk_rdata, which it drives.
// Notes: Host changes strobes, address and data while the link clock is low.
`timescale 1ns/100ps
`default_nettype none
interface lmbs_if;
  logic lnk_clk;
  logic lnk_wr;
  logic lnk_rd;
  logic [7:0] lnk_addr;
  logic [7:0] lnk_wdata;
  logic [7:0] lnk_rdata;
  modport dev (input lnk_clk, input lnk_wr, input lnk_rd, input lnk_addr, input lnk_wdata,
    output lnk_rdata);
  modport host (output lnk_clk, output lnk_wr, output lnk_rd, output lnk_addr,
    output lnk_wdata, input lnk_rdata);
endinterface
`default_nettype wire

/* hdl/lmbs_map.svh */
// Purpose: Offsets, field positions, reset values and timing for the LED matrix block.
// Assumes: 8-bit registers on the link, core clock of 10 MHz.
// Notes: Definitions only.
`ifndef LMBS_MAP_SVH
`define LMBS_MAP_SVH
// ****************************************************************
// Device register map
// ****************************************************************
`define LMBS_CFG 8'h00
`define LMBS_GCC 8'h01
`define LMBS_TIME_FIRST 8'h02
`define LMBS_TIME_LAST 8'h0d
`define LMBS_COMMIT 8'h0e
`define LMBS_PULLUP 8'h0f
`define LMBS_PULLDOWN 8'h10
`define LMBS_RESET 8'h11
`define LMBS_OPEN_LO 8'h18
`define LMBS_OPEN_HI 8'h19
`define LMBS_SHORT_LO 8'h30
`define LMBS_SHORT_HI 8'h31
`define LMBS_PWM_BASE 8'h50
`define LMBS_MODE_BASE 8'h60
`define LMBS_ONOFF_LO 8'h70
`define LMBS_ONOFF_HI 8'h71
`define LMBS_COMMIT_KEY 8'h00
`define LMBS_REG_RESET 8'h00
// Configuration bits.
`define LMBS_CFG_SSD 0
`define LMBS_CFG_BEN 1
`define LMBS_CFG_DET 2
// ****************************************************************
// Timing
// ****************************************************************
`define LMBS_CLK_NS 100
`define LMBS_SLOT_NS 128000
`define LMBS_GAP_NS 8000
`define LMBS_BASE_TICKS 2100000
`define LMBS_DET_FRAMES 2'h2
// ****************************************************************
// Host register map and link timing
// ****************************************************************
`define LMBS_H_ADDR 3'h0
`define LMBS_H_WDATA 3'h1
`define LMBS_H_CTRL 3'h2
`define LMBS_H_STATUS 3'h3
`define LMBS_H_RDATA 3'h4
`define LMBS_LNK_HALF 3'h4
`endif

/* hdl/lmbs_pkg.sv */
// Purpose: Types shared by both ends of the LED matrix link.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Constants live in lmbs_map.svh.
package lmbs_pkg;
  typedef enum logic [2:0] {PH_RISE, PH_HOLD, PH_FALL, PH_OFF, PH_DONE} lmbs_phase_e;
  typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_HIGH, HS_TAIL} lmbs_hstate_e;
  typedef logic [7:0] lmbs_byte_t;
endpackage

/* test/lmbs_chk.sv */
// Purpose: Protocol checks on the link between host and device ends.
// Assumes: The host end makes the link clock from the core clock.
// Notes: Sees the interface wires only.
`timescale 1ns/100ps
`default_nettype none
module lmbs_chk (
  input wire logic core_clk_in, // Core clock.
  input wire logic rst_n_in, // Reset, active low.
  input wire logic lnk_clk, // Link clock.
  input wire logic lnk_wr, // Write strobe.
  input wire logic lnk_rd, // Read strobe.
  input wire logic [7:0] lnk_addr, // Register address.
  input wire logic [7:0] lnk_wdata, // Write data.
  input wire logic [7:0] lnk_rdata // Read data.
);
  // ****
  // Checks
  // ****
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_clk_in_xfer: assert property (lnk_clk |-> lnk_wr || lnk_rd)
    else $error("link clock high outside a transfer");
  a_clk_high_four: assert property ($rose(lnk_clk) |-> lnk_clk [*4] ##1 !lnk_clk)
    else $error("link clock high time wrong");
  a_fall_drops_stb: assert property ($fell(lnk_clk) |-> !lnk_wr && !lnk_rd)
    else $error("strobe still up after link clock fell");
  a_setup_before: assert property ($rose(lnk_clk) |-> $past(lnk_wr || lnk_rd, 2))
    else $error("strobe not set up before link clock");
  a_fields_steady: assert property (lnk_clk |-> $stable(lnk_addr) && $stable(lnk_wdata))
    else $error("address or data moved while link clock high");
  a_one_strobe: assert property (!(lnk_wr && lnk_rd))
    else $error("write and read strobes together");
  a_reset_read_zero: assert property ($rose(lnk_clk) && lnk_rd && lnk_addr == 8'h11
    |-> ##[1:8] lnk_rdata == 8'h00)
    else $error("reset register read did not return zero");
  a_rdata_holds: assert property ($changed(lnk_rdata) |-> lnk_rd || $past(lnk_rd))
    else $error("read data moved without a read");
endmodule // lmbs_chk
`default_nettype wire

/* test/lmbs_tb_top.sv */
// Purpose: Self-checking bench for both ends of the LED matrix link.
// Assumes: Breath unit shortened to 10 core cycles.
// Notes: All orders go through the host software port.
`timescale 1ns/100ps
`default_nettype none
module led_matrix_breath_scan_ctrl_tb_top;
  logic clk, rst_n, sw_wr, sw_rd;
  logic [2:0] sw_addr, row, puc, pue, pdc;
  logic [3:0] col, pde;
  logic [7:0] sw_wdata, sw_rdata, gcv, rd_v;
  logic [11:0] op, sh;
  int error_cnt, checks_done, cc[4];
  lmbs_if lnk ();
  lmbs_host u_lmbs_host (.core_clk_in(clk), .rst_n_in(rst_n), .lnk(lnk), .sw_addr_in(sw_addr),
    .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd), .sw_rdata_out(sw_rdata));
  lmbs_dev #(.BASE_TICKS(10240)) u_lmbs_dev (.core_clk_in(clk), .rst_n_in(rst_n), .lnk(lnk),
    .dot_open_in(op), .dot_short_in(sh), .row_switch_out(row), .column_source_out(col),
    .global_current_value_out(gcv), .row_pullup_code_out(puc), .row_pullup_en_out(pue),
    .column_pulldown_code_out(pdc), .column_pulldown_en_out(pde));
  lmbs_chk u_lmbs_chk (.core_clk_in(clk), .rst_n_in(rst_n), .lnk_clk(lnk.lnk_clk),
    .lnk_wr(lnk.lnk_wr), .lnk_rd(lnk.lnk_rd), .lnk_addr(lnk.lnk_addr),
    .lnk_wdata(lnk.lnk_wdata), .lnk_rdata(lnk.lnk_rdata));
  // ****
  // Tasks
  // ****
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bail();
    error_cnt++;
    tally_and_finish();
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic sw(input logic [2:0] a, input logic [7:0] d, input logic r);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= !r;
    sw_rd <= r;
    @(posedge clk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    #1 rd_v = sw_rdata;
  endtask
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic r);
    int k = 0;
    sw(3'h0, a, 1'b0);
    sw(3'h1, d, 1'b0);
    sw(3'h2, {6'h0, r, !r}, 1'b0);
    do begin
      sw(3'h3, 8'h00, 1'b1);
      k++;
    end while (rd_v[1] !== 1'b1 && k < 99);
    if (rd_v[1] !== 1'b1) bail();
    if (r) sw(3'h4, 8'h00, 1'b1);
  endtask
  task automatic wrs(input logic [15:0] w[$]);
    foreach (w[i]) xfer(w[i][15:8], w[i][7:0], 1'b0);
  endtask
  task automatic till(input logic [2:0] p);
    int k = 0;
    while (row !== p) begin
      @(posedge clk);
      #1 k++;
      if (k > 9000) bail();
    end
  endtask
  task automatic span(input logic [2:0] p, input int e);
    int k = 0;
    while (row === p && k < 9000) begin
      @(posedge clk);
      #1 k++;
    end
    chk(16'(k), 16'(e));
  endtask
  // Counts the on cycles of every column over one whole row 0 slot.
  task automatic colcnt();
    cc = '{0, 0, 0, 0};
    till(3'b010);
    till(3'b001);
    for (int k = 0; k < 2000 && row === 3'b001; k++) begin
      foreach (cc[i]) cc[i] += int'(col[i]);
      @(posedge clk);
      #1;
    end
  endtask
  task automatic t_rst();
    chk({row, col, gcv, 1'b0}, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      xfer(8'h0f, {5'h1f, 3'(c)}, 1'b0);
      xfer(8'h10, {5'h1f, 3'(7 - c)}, 1'b0);
      chk({10'h0, puc, pdc}, {10'h0, 3'(c), 3'(7 - c)});
      chk({9'h0, pue, pde}, {9'h0, {3{c != 0}}, {4{c != 7}}});
    end
    xfer(8'h01, 8'hb5, 1'b0);
    chk({8'h0, gcv}, 16'h00b5);
    xfer(8'h11, 8'h00, 1'b1);
    chk({gcv, 2'h0, puc, pdc}, 16'h0000);
    $display("test reset and pulls done");
  endtask
  task automatic t_scan();
    xfer(8'h00, 8'h01, 1'b0);
    till(3'b010);
    till(3'b001);
    span(3'b001, 1280);
    span(3'b000, 80);
    span(3'b010, 1280);
    span(3'b000, 80);
    chk({13'h0, row}, 16'h0004);
    xfer(8'h00, 8'h00, 1'b0);
    repeat (1400) @(posedge clk);
    #1 chk({9'h0, row, col}, 16'h0000);
    $display("test scan done");
  endtask
  task automatic t_pwm();
    logic [15:0] e[4] = '{16'd514, 16'd0, 16'd1023, 16'd4};
    wrs('{16'h70ff, 16'h5080, 16'h52ff, 16'h5301, 16'h0001});
    colcnt();
    foreach (cc[i]) chk(16'(cc[i]), e[i]);
    $display("test pwm done");
  endtask
  task automatic t_breath();
    wrs('{16'h6001, 16'h6102, 16'h6203, 16'h02e0, 16'h0820, 16'h0e55, 16'h0003});
    repeat (6000) @(posedge clk);
    colcnt();
    chk({13'h0, cc[0] > 512, cc[1] > 512, cc[2] > 512}, 16'h0007);
    chk(16'(cc[3]), 16'd4);
    wrs('{16'h0e00});
    repeat (6000) @(posedge clk);
    colcnt();
    chk({13'h0, cc[0] < 64, cc[1] < 128, cc[2] > 512}, 16'h0007);
    wrs('{16'h0001});
    colcnt();
    chk(16'(cc[0]), 16'd514);
    $display("test breath done");
  endtask
  task automatic t_det();
    logic [7:0] ex[4];
    ex = '{op[7:0] & 8'hdf, {4'h0, op[11:8]}, sh[7:0] & 8'hdf, {4'h0, sh[11:8]}};
    wrs('{16'h70df, 16'h710f, 16'h0101, 16'h0005});
    repeat (9000) @(posedge clk);
    op <= ~op;
    for (int i = 0; i < 4; i++) begin
      xfer(i < 2 ? 8'h18 + 8'(i) : 8'h2e + 8'(i), 8'h00, 1'b1);
      chk({8'h0, rd_v}, {8'h0, ex[i]});
    end
    $display("test detect done");
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rst_n, sw_wr, sw_rd, sw_addr, sw_wdata} = '0;
    op = 12'ha5c;
    sh = 12'h3c9;
    error_cnt = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1 t_rst();
    t_scan();
    t_pwm();
    t_breath();
    t_det();
    tally_and_finish();
  end
endmodule // led_matrix_breath_scan_ctrl_tb_top
`default_nettype wire
